// ### design/rpa_pkg.sv
// shared constants for the row repair and activate limit block
// assumes one 125 MHz device clock and decoded commands from a controller
//
// Contract
// - background row protection; limit code reads 1000
// - limit code in bits 3:0, upper don't care
// - soft repair is temporary and replaceable
// - hard repair permanent; no repairs over it
// - page 2 location 0 shows repair support
// - one repair row per bank, 16 or 8
// - hard entry allowed with soft repairs recorded
// - banks repair independently of each other
// - soft over soft reuses the row
// - hard over soft takes the row
// - hard repair never cleared or overwritten; reset clears it here
// - mode register four bits 13 and 5
// - write-autoprecharge form keeps other banks refreshed
// - plain write form: no refresh, no retention
// - four guard keys to register zero, spaced
package rpa_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int BANKS = 16;
  localparam int BANK_W = 4;
  localparam int ROW_W = 18;
  localparam int ADDR_W = 18;

  // ---------------------------------------------------------------
  // command and state encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RPA_CMD_NOP = 3'b000,
    RPA_CMD_MRS = 3'b001,
    RPA_CMD_ACT = 3'b010,
    RPA_CMD_WR = 3'b011,
    RPA_CMD_WRA = 3'b100,
    RPA_CMD_PRE = 3'b101,
    RPA_CMD_REF = 3'b110,
    RPA_CMD_MPR = 3'b111
  } rpa_cmd_e;

  typedef enum logic [1:0] {
    RPA_FIX_EMPTY = 2'b00,
    RPA_FIX_SOFT = 2'b01,
    RPA_FIX_HARD = 2'b10
  } rpa_fix_e;

  // ---------------------------------------------------------------
  // mode registers and guard keys
  // ---------------------------------------------------------------
  localparam logic [3:0] MR_SEL_ZERO = 4'h0;
  localparam logic [3:0] MR_SEL_FOUR = 4'h4;
  localparam int MR4_HARD_BIT = 13;
  localparam int MR4_SOFT_BIT = 5;
  localparam logic [4:0] GUARD_KEY0 = 5'h19;
  localparam logic [4:0] GUARD_KEY1 = 5'h0F;
  localparam logic [4:0] GUARD_KEY2 = 5'h17;
  localparam logic [4:0] GUARD_KEY3 = 5'h07;
  localparam logic [6:0] GUARD_LOW_ONES = 7'h7F;
  localparam logic [2:0] GUARD_STEPS = 3'h4;
  // mode-set delay between guard keys, in device clocks
  localparam logic [7:0] MODE_SET_CYCLES = 8'h18;

  // ---------------------------------------------------------------
  // readout pages
  // ---------------------------------------------------------------
  localparam logic [1:0] PAGE_TWO = 2'h2;
  localparam logic [1:0] PAGE_THREE = 2'h3;
  localparam logic [1:0] LOC_ZERO = 2'h0;
  localparam logic [1:0] LOC_THREE = 2'h3;
  localparam int HARD_SUPPORT_BIT = 7;
  localparam int SOFT_SUPPORT_BIT = 6;
  localparam logic [3:0] ACT_LIMIT_UNLIMITED = 4'h8;
  localparam logic [7:0] RD_DATA_RESET = 8'h00;

endpackage : rpa_pkg

// ### design/rpa_guard_keys.sv
// guard key checker for repair entry
// assumes commands are decoded and valid for one clock each
`timescale 1ns/1ns
module rpa_guard_keys (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // decoded command
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_in,
  input wire logic [3:0] mr_sel_in,
  input wire logic [17:0] addr_in,
  // a repair mode bit is set
  input wire logic mode_on_in,
  // all four keys accepted
  output logic keys_ok_out
);

  // ---------------------------------------------------------------
  // key sequencing
  // ---------------------------------------------------------------
  logic [2:0] step;
  logic [2:0] next_step;
  logic [7:0] gap;
  logic [7:0] next_gap;
  logic [4:0] want;
  logic is_mr0;

  // expected key for the current step
  always_comb
  begin
    case (step)
      3'h0: want = rpa_pkg::GUARD_KEY0;
      3'h1: want = rpa_pkg::GUARD_KEY1;
      3'h2: want = rpa_pkg::GUARD_KEY2;
      default: want = rpa_pkg::GUARD_KEY3;
    endcase
  end

  assign is_mr0 = cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MRS &&
                  mr_sel_in == rpa_pkg::MR_SEL_ZERO;

  // any stray command or early key drops the sequence
  always_comb
  begin
    next_step = step;
    next_gap = (gap == rpa_pkg::MODE_SET_CYCLES) ? gap : gap + 8'h01;
    if (!mode_on_in)
      next_step = 3'h0;
    else if (is_mr0 && step != rpa_pkg::GUARD_STEPS &&
             addr_in[11:7] == want &&
             addr_in[6:0] == rpa_pkg::GUARD_LOW_ONES &&
             (step == 3'h0 || gap == rpa_pkg::MODE_SET_CYCLES))
    begin
      next_step = step + 3'h1;
      next_gap = 8'h01;
    end
    else if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MRS &&
             step != rpa_pkg::GUARD_STEPS)
      next_step = 3'h0;
    else if (cmd_valid_in && step != rpa_pkg::GUARD_STEPS &&
             step != 3'h0 && cmd_in != rpa_pkg::RPA_CMD_NOP)
      next_step = 3'h0;
  end

  // registers only
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      step <= 3'h0;
      gap <= 8'h00;
    end
    else
    begin
      step <= next_step;
      gap <= next_gap;
    end
  end

  assign keys_ok_out = (step == rpa_pkg::GUARD_STEPS);

endmodule : rpa_guard_keys

// ### design/rpa_row_store.sv
// repair address store, one row word per bank
// assumes single writer; read data is registered
`timescale 1ns/1ns
module rpa_row_store (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [3:0] wr_bank_in,
  input wire logic [17:0] wr_row_in,
  // read port
  input wire logic [3:0] rd_bank_in,
  output logic [17:0] rd_row_out
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [17:0] mem [rpa_pkg::BANKS];
  logic [17:0] next_rd_row;

  // read mux ahead of the output register
  always_comb
  begin
    next_rd_row = mem[rd_bank_in];
  end

  // array write and registered read
  always_ff @(posedge mclk_in)
  begin
    if (wr_en_in)
      mem[wr_bank_in] <= wr_row_in;
    if (rst_in)
      rd_row_out <= 18'h00000;
    else
      rd_row_out <= next_rd_row;
  end

endmodule : rpa_row_store

// ### design/rpa_row_repair.sv
// row repair bookkeeping and activate limit readout
// assumes decoded controller commands, one per clock, on mclk_in
`timescale 1ns/1ns
module rpa_row_repair (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // organisation strap, high for sixteen-bit-wide part
  input wire logic cfg_x16_in,
  // command bus
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_in,
  input wire logic [3:0] bank_in,
  input wire logic [17:0] addr_in,
  input wire logic wr_data_low_in,
  // readout selection for readout commands
  input wire logic [1:0] page_in,
  input wire logic [1:0] loc_in,
  // repair query
  input wire logic [3:0] query_bank_in,
  // readout answer
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // repair status
  output logic hard_mode_out,
  output logic soft_mode_out,
  output logic armed_out,
  output logic repair_done_out,
  output logic [15:0] data_loss_mask_out,
  output logic no_retention_out,
  output logic ref_violation_out,
  output logic [1:0] query_state_out,
  output logic [17:0] query_row_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rpa_pkg::rpa_fix_e bank_state [rpa_pkg::BANKS];
  rpa_pkg::rpa_fix_e next_bank_state [rpa_pkg::BANKS];
  logic x16;
  logic strap_taken;
  logic act_open;
  logic next_act_open;
  logic [3:0] act_bank;
  logic [3:0] next_act_bank;
  logic [17:0] act_row;
  logic [17:0] next_act_row;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic next_hard_mode;
  logic next_soft_mode;
  logic next_repair_done;
  logic [15:0] next_loss_mask;
  logic next_no_ret;
  logic next_ref_viol;
  logic [1:0] next_query_state;
  logic keys_ok;
  logic armed;
  logic bank_ok;
  logic fire;
  logic store_wr;
  logic [15:0] hard_vec;
  logic [15:0] soft_vec;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  rpa_guard_keys u_keys (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in),
    .mr_sel_in(bank_in),
    .addr_in(addr_in),
    .mode_on_in(hard_mode_out | soft_mode_out),
    .keys_ok_out(keys_ok)
  );

  rpa_row_store u_store (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_en_in(store_wr),
    .wr_bank_in(act_bank),
    .wr_row_in(act_row),
    .rd_bank_in(query_bank_in),
    .rd_row_out(query_row_out)
  );

  // per-bank flags for the checks
  genvar gi;
  generate
    for (gi = 0; gi < rpa_pkg::BANKS; gi++)
    begin : g_bank
      assign hard_vec[gi] = (bank_state[gi] == rpa_pkg::RPA_FIX_HARD);
      assign soft_vec[gi] = (bank_state[gi] == rpa_pkg::RPA_FIX_SOFT);
    end
  endgenerate

  // ---------------------------------------------------------------
  // repair decision
  // ---------------------------------------------------------------
  // upper eight banks do not exist on the wide part
  assign bank_ok = !x16 || !bank_in[3];
  // exactly one mode, keys done; both modes set never arms
  assign armed = keys_ok && (hard_mode_out ^ soft_mode_out);
  // repair fires on the write whose burst is all low
  assign fire = armed && act_open && cmd_valid_in && bank_ok &&
                (cmd_in == rpa_pkg::RPA_CMD_WR ||
                 cmd_in == rpa_pkg::RPA_CMD_WRA) &&
                bank_in == act_bank && wr_data_low_in;
  // a hard bank keeps its row, so the store is not written
  assign store_wr = fire &&
                    bank_state[act_bank] != rpa_pkg::RPA_FIX_HARD;

  // next values for mode, activate and repair state
  always_comb
  begin
    next_hard_mode = hard_mode_out;
    next_soft_mode = soft_mode_out;
    next_act_open = act_open;
    next_act_bank = act_bank;
    next_act_row = act_row;
    next_repair_done = 1'b0;
    next_loss_mask = data_loss_mask_out;
    next_no_ret = no_retention_out;
    next_ref_viol = ref_violation_out;
    for (int i = 0; i < rpa_pkg::BANKS; i++)
      next_bank_state[i] = bank_state[i];
    // mode bits; entry is allowed over soft repairs
    if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MRS &&
        bank_in == rpa_pkg::MR_SEL_FOUR)
    begin
      next_hard_mode = addr_in[rpa_pkg::MR4_HARD_BIT];
      next_soft_mode = addr_in[rpa_pkg::MR4_SOFT_BIT];
      if (!addr_in[rpa_pkg::MR4_HARD_BIT])
      begin
        next_loss_mask = 16'h0000;
        next_no_ret = 1'b0;
        next_ref_viol = 1'b0;
      end
    end
    // activate captures the failing bank and row
    if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_ACT && bank_ok)
    begin
      next_act_open = 1'b1;
      next_act_bank = bank_in;
      next_act_row = addr_in;
    end
    if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_PRE)
      next_act_open = 1'b0;
    if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_WRA)
      next_act_open = 1'b0;
    // replacement: one bank only is touched
    if (fire)
    begin
      next_repair_done = 1'b1;
      case (bank_state[act_bank])
        rpa_pkg::RPA_FIX_EMPTY,
        rpa_pkg::RPA_FIX_SOFT:
          // soft reused or taken over by hard
          next_bank_state[act_bank] = hard_mode_out ?
            rpa_pkg::RPA_FIX_HARD : rpa_pkg::RPA_FIX_SOFT;
        rpa_pkg::RPA_FIX_HARD:
          // permanent, left as is
          next_bank_state[act_bank] = rpa_pkg::RPA_FIX_HARD;
        default:
          next_bank_state[act_bank] = rpa_pkg::RPA_FIX_EMPTY;
      endcase
      if (hard_mode_out && cmd_in == rpa_pkg::RPA_CMD_WRA)
      begin
        // bank under repair and its pair differing in bit 0
        next_loss_mask[{act_bank[3:1], 1'b0}] = 1'b1;
        next_loss_mask[{act_bank[3:1], 1'b1}] = 1'b1;
      end
      if (hard_mode_out && cmd_in == rpa_pkg::RPA_CMD_WR)
        next_no_ret = 1'b1;
    end
    // refresh in the plain write form is flagged
    if (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_REF &&
        (no_retention_out || next_no_ret))
      next_ref_viol = 1'b1;
  end

  // ---------------------------------------------------------------
  // readout
  // ---------------------------------------------------------------
  // readout locations; limit is fixed unlimited
  always_comb
  begin
    next_rd_data = 8'h00;
    next_rd_valid = cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MPR;
    next_query_state = bank_state[query_bank_in];
    if (page_in == rpa_pkg::PAGE_TWO && loc_in == rpa_pkg::LOC_ZERO)
    begin
      next_rd_data[rpa_pkg::HARD_SUPPORT_BIT] = 1'b1;
      next_rd_data[rpa_pkg::SOFT_SUPPORT_BIT] = 1'b1;
    end
    else if (page_in == rpa_pkg::PAGE_THREE &&
             loc_in == rpa_pkg::LOC_THREE)
      next_rd_data[3:0] = rpa_pkg::ACT_LIMIT_UNLIMITED;
    if (!next_rd_valid)
      next_rd_data = rd_data_out;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // strap caught on the first clock after reset release
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      x16 <= 1'b0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      x16 <= cfg_x16_in;
      strap_taken <= 1'b1;
    end
  end

  // repair state is volatile here; hard rows persist until reset
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < rpa_pkg::BANKS; i++)
        bank_state[i] <= rpa_pkg::RPA_FIX_EMPTY;
      hard_mode_out <= 1'b0;
      soft_mode_out <= 1'b0;
      armed_out <= 1'b0;
      act_open <= 1'b0;
      act_bank <= 4'h0;
      act_row <= 18'h00000;
      repair_done_out <= 1'b0;
      data_loss_mask_out <= 16'h0000;
      no_retention_out <= 1'b0;
      ref_violation_out <= 1'b0;
      rd_data_out <= rpa_pkg::RD_DATA_RESET;
      rd_valid_out <= 1'b0;
      query_state_out <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < rpa_pkg::BANKS; i++)
        bank_state[i] <= next_bank_state[i];
      hard_mode_out <= next_hard_mode;
      soft_mode_out <= next_soft_mode;
      armed_out <= armed;
      act_open <= next_act_open;
      act_bank <= next_act_bank;
      act_row <= next_act_row;
      repair_done_out <= next_repair_done;
      data_loss_mask_out <= next_loss_mask;
      no_retention_out <= next_no_ret;
      ref_violation_out <= next_ref_viol;
      rd_data_out <= next_rd_data;
      rd_valid_out <= next_rd_valid;
      query_state_out <= next_query_state;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_limit_code;
    @(posedge mclk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MPR &&
     page_in == 2'h3 && loc_in == 2'h3) |=>
      rd_valid_out && rd_data_out[3:0] == 4'h8;
  endproperty
  a_limit_code: assert property (p_limit_code)
    else $error("limit code not unlimited");

  property p_support_bits;
    @(posedge mclk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in == rpa_pkg::RPA_CMD_MPR &&
     page_in == 2'h2 && loc_in == 2'h0) |=> rd_data_out[7:6] == 2'b11;
  endproperty
  a_support_bits: assert property (p_support_bits)
    else $error("repair support bits missing");

  property p_hard_sticks;
    @(posedge mclk_in) disable iff (rst_in)
    ($past(hard_vec) & ~hard_vec) == 16'h0000;
  endproperty
  a_hard_sticks: assert property (p_hard_sticks)
    else $error("hard repair was lost");

  property p_one_bank;
    @(posedge mclk_in) disable iff (rst_in)
    $countones({hard_vec, soft_vec} ^ $past({hard_vec, soft_vec})) <= 2
      && ($past(fire) || $stable(soft_vec));
  endproperty
  a_one_bank: assert property (p_one_bank)
    else $error("repair touched another bank");

  property p_mode_result;
    @(posedge mclk_in) disable iff (rst_in)
    (fire && !hard_vec[act_bank]) |=>
      repair_done_out && (soft_mode_out ? soft_vec[$past(act_bank)]
                                        : hard_vec[$past(act_bank)]);
  endproperty
  a_mode_result: assert property (p_mode_result)
    else $error("bank state not set by repair");

  property p_arm_single;
    @(posedge mclk_in) disable iff (rst_in)
    armed_out |-> $past(keys_ok) && !(hard_mode_out && soft_mode_out);
  endproperty
  a_arm_single: assert property (p_arm_single)
    else $error("armed without keys or with both modes");

  property p_keys_cause;
    @(posedge mclk_in) disable iff (rst_in)
    $rose(keys_ok) |-> $past(cmd_valid_in) && $past(bank_in) == 4'h0 &&
      $past(addr_in[11:0]) == 12'h3FF;
  endproperty
  a_keys_cause: assert property (p_keys_cause)
    else $error("keys done without fourth key");

  property p_loss_mask;
    @(posedge mclk_in) disable iff (rst_in)
    (data_loss_mask_out != 16'h0000 || no_retention_out) |->
      hard_mode_out;
  endproperty
  a_loss_mask: assert property (p_loss_mask)
    else $error("retention flags outside hard mode");

  property p_ref_flag;
    @(posedge mclk_in) disable iff (rst_in)
    $rose(ref_violation_out) |-> $past(cmd_in) == rpa_pkg::RPA_CMD_REF
      && no_retention_out;
  endproperty
  a_ref_flag: assert property (p_ref_flag)
    else $error("refresh flag without cause");

endmodule : rpa_row_repair

// ### bench/rpa_ctrl_model.sv
// controller model: decoded repair, mode and readout commands
// assumes the bench calls its tasks; drives on the falling edge
`timescale 1ns/1ns
module rpa_ctrl_model (
  // clock
  input wire logic mclk_in,
  // command bus towards the device
  output logic cmd_valid_out,
  output logic [2:0] cmd_out,
  output logic [3:0] bank_out,
  output logic [17:0] addr_out,
  output logic wr_data_low_out,
  output logic [1:0] page_out,
  output logic [1:0] loc_out
);
  // ---------------------------------------------------------------
  // command tasks
  // ---------------------------------------------------------------
  logic [4:0] key_tab [4] = '{rpa_pkg::GUARD_KEY0, rpa_pkg::GUARD_KEY1,
    rpa_pkg::GUARD_KEY2, rpa_pkg::GUARD_KEY3};

  // bus parks idle at time zero
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_out = rpa_pkg::RPA_CMD_NOP;
    bank_out = 4'h0;
    addr_out = 18'h00000;
    wr_data_low_out = 1'b0;
    page_out = 2'h0;
    loc_out = 2'h0;
  end

  // one-cycle command; released address and data-low turn inverse so stale data shows, bank holds
  task automatic issue(input logic [2:0] c, input logic [3:0] b,
                       input logic [17:0] a, input logic lo);
    @(negedge mclk_in);
    cmd_valid_out = 1'b1;
    cmd_out = c;
    bank_out = b;
    addr_out = a;
    wr_data_low_out = lo;
    @(negedge mclk_in);
    cmd_valid_out = 1'b0;
    cmd_out = rpa_pkg::RPA_CMD_NOP;
    addr_out = ~a;
    wr_data_low_out = ~lo;
  endtask : issue

  // readout request
  task automatic mpr(input logic [1:0] p, input logic [1:0] l);
    page_out = p;
    loc_out = l;
    issue(rpa_pkg::RPA_CMD_MPR, 4'h0, 18'h00000, 1'b0);
  endtask : mpr

  // only one repair mode bit is ever set at a time
  task automatic enter(input logic hard);
    issue(rpa_pkg::RPA_CMD_MRS, rpa_pkg::MR_SEL_FOUR,
          hard ? 18'h02000 : 18'h00020, 1'b0);
  endtask : enter

  // mode off after every repair, so the next one starts clean
  task automatic leave();
    issue(rpa_pkg::RPA_CMD_MRS, rpa_pkg::MR_SEL_FOUR, 18'h00000,
          1'b0);
  endtask : leave

  // four keys to register zero; a gap of fewer than 23 idle clocks breaks it
  task automatic keys(input int gap);
    for (int i = 0; i < 4; i++)
    begin
      issue(rpa_pkg::RPA_CMD_MRS, rpa_pkg::MR_SEL_ZERO,
            {6'h00, key_tab[i], rpa_pkg::GUARD_LOW_ONES}, 1'b0);
      if (i < 3)
        repeat (gap) @(negedge mclk_in);
    end
  endtask : keys

  // one activate per repair keeps any row far below its limit
  task automatic fix(input logic wra, input logic [3:0] b,
                     input logic [17:0] r, input logic do_ref);
    issue(rpa_pkg::RPA_CMD_ACT, b, r, 1'b0);
    issue(wra ? rpa_pkg::RPA_CMD_WRA : rpa_pkg::RPA_CMD_WR, b, ~r, 1'b1);
    if (do_ref)
      issue(rpa_pkg::RPA_CMD_REF, 4'h0, 18'h00000, 1'b0);
    issue(rpa_pkg::RPA_CMD_PRE, b, 18'h00000, 1'b0);
  endtask : fix
endmodule : rpa_ctrl_model

// ### bench/rpa_row_repair_tb_top.sv
// top bench: repair bookkeeping and readout codes
// assumes the controller model drives the command bus
`timescale 1ns/1ns
`define CHK(name, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module rpa_row_repair_tb_top;
  logic mclk_in, rst_in, cfg_x16_in, cmd_valid, wr_low, rd_valid_out;
  logic [2:0] cmd;
  logic [3:0] bank, query_bank_in;
  logic [17:0] addr, query_row_out;
  logic [1:0] page, loc, query_state_out;
  logic [7:0] rd_data_out;
  logic hard_mode_out, soft_mode_out, armed_out, repair_done_out;
  logic no_retention_out, ref_violation_out;
  logic [15:0] data_loss_mask_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed;
  logic [8:0] e, m, got_ev;
  logic [8:0] exp_q[$];
  logic [17:0] rows [4];

  rpa_ctrl_model u_rpa_ctrl_model (.mclk_in(mclk_in),
    .cmd_valid_out(cmd_valid), .cmd_out(cmd), .bank_out(bank),
    .addr_out(addr), .wr_data_low_out(wr_low), .page_out(page),
    .loc_out(loc));

  rpa_row_repair u_rpa_row_repair (.mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_x16_in(cfg_x16_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .bank_in(bank), .addr_in(addr), .wr_data_low_in(wr_low),
    .page_in(page), .loc_in(loc), .query_bank_in(query_bank_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .hard_mode_out(hard_mode_out), .soft_mode_out(soft_mode_out),
    .armed_out(armed_out), .repair_done_out(repair_done_out),
    .data_loss_mask_out(data_loss_mask_out),
    .no_retention_out(no_retention_out),
    .ref_violation_out(ref_violation_out),
    .query_state_out(query_state_out), .query_row_out(query_row_out));

  // 125 MHz clock
  initial mclk_in = 1'b0;
  always #4 mclk_in = ~mclk_in;

  // ---------------------------------------------------------------
  // result watcher: readout bytes and repair pulses, oldest note first
  // ---------------------------------------------------------------
  always @(posedge mclk_in)
  begin
    #1;
    if (rd_valid_out === 1'b1 || repair_done_out === 1'b1)
    begin
      m = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1FF;
      got_ev = {rd_valid_out, rd_data_out & {8{rd_valid_out}}};
      `CHK("event", m, got_ev)
    end
  end

  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // hang guard, far beyond the longest sequence
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    stop_test();
  end

  // recorded state and row of one bank
  task automatic qchk(input logic [3:0] b, input logic [1:0] st,
                      input logic [17:0] r);
    @(negedge mclk_in);
    query_bank_in = b;
    @(negedge mclk_in);
    `CHK("query_state", st, query_state_out)
    if (st != 2'h0)
      `CHK("query_row", r, query_row_out)
  endtask : qchk

  // full repair: mode, keys, fix, then flags and mode off
  task automatic do_fix(input logic hard, input logic wra,
                        input logic [3:0] b, input logic [17:0] r,
                        input logic do_ref, input logic fl);
    logic [15:0] exp_mask;
    u_rpa_ctrl_model.enter(hard);
    @(negedge mclk_in);
    `CHK("hard_mode", hard, hard_mode_out)
    `CHK("soft_mode", ~hard, soft_mode_out)
    u_rpa_ctrl_model.keys(24);
    repeat (2) @(negedge mclk_in);
    `CHK("armed", 1'b1, armed_out)
    exp_q.push_back(9'h000);
    u_rpa_ctrl_model.fix(wra, b, r, do_ref);
    if (fl)
    begin
      exp_mask = (hard & wra) ? 16'h0003 << (b & 4'hE) : 16'h0000;
      `CHK("loss_mask", exp_mask, data_loss_mask_out)
      `CHK("no_retention", hard & ~wra, no_retention_out)
      `CHK("ref_violation", do_ref, ref_violation_out)
    end
    u_rpa_ctrl_model.leave();
    @(negedge mclk_in);
    `CHK("loss_cleared", 16'h0000, data_loss_mask_out)
  endtask : do_fix

  // main sequence
  initial
  begin
    seed = 32'h4e87d7b2;
    rst_in = 1'b1;
    cfg_x16_in = 1'b0;
    query_bank_in = 4'h0;
    repeat (16) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 4; i++)
      rows[i] = 18'($random(seed));
    // every page and location; only two carry codes
    for (int p = 0; p < 4; p++)
      for (int l = 0; l < 4; l++)
      begin
        e = (p == 3 && l == 3) ? {5'h10, rpa_pkg::ACT_LIMIT_UNLIMITED} :
            (p == 2 && l == 0) ? 9'h1C0 : 9'h100;
        exp_q.push_back(e);
        u_rpa_ctrl_model.mpr(p[1:0], l[1:0]);
      end
    do_fix(1'b0, 1'b0, 4'h3, rows[0], 1'b0, 1'b1);
    qchk(4'h3, 2'h1, rows[0]);
    do_fix(1'b0, 1'b0, 4'h3, rows[1], 1'b0, 1'b1);
    qchk(4'h3, 2'h1, rows[1]);
    do_fix(1'b0, 1'b0, 4'hF, rows[2], 1'b0, 1'b1);
    qchk(4'hF, 2'h1, rows[2]);
    do_fix(1'b1, 1'b1, 4'h3, rows[3], 1'b0, 1'b1);
    qchk(4'h3, 2'h2, rows[3]);
    qchk(4'hF, 2'h1, rows[2]);
    do_fix(1'b0, 1'b0, 4'h3, rows[0], 1'b0, 1'b0);
    do_fix(1'b1, 1'b1, 4'h3, rows[1], 1'b0, 1'b0);
    qchk(4'h3, 2'h2, rows[3]);
    do_fix(1'b1, 1'b0, 4'h9, rows[1], 1'b1, 1'b1);
    qchk(4'h9, 2'h2, rows[1]);
    qchk(4'hF, 2'h1, rows[2]);
    // keys spaced too closely: no arming, the autoprecharge write repairs nothing
    u_rpa_ctrl_model.enter(1'b1);
    u_rpa_ctrl_model.keys(10);
    repeat (2) @(negedge mclk_in);
    `CHK("armed_early", 1'b0, armed_out)
    u_rpa_ctrl_model.fix(1'b1, 4'h7, rows[2], 1'b0);
    u_rpa_ctrl_model.leave();
    qchk(4'h7, 2'h0, rows[2]);
    // mid-run reset with the wide strap: state clears, upper banks vanish
    @(negedge mclk_in);
    rst_in = 1'b1;
    cfg_x16_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    rst_in = 1'b0;
    u_rpa_ctrl_model.enter(1'b0);
    u_rpa_ctrl_model.keys(24);
    u_rpa_ctrl_model.fix(1'b0, 4'hB, rows[0], 1'b0);
    u_rpa_ctrl_model.leave();
    qchk(4'hB, 2'h0, rows[0]);
    do_fix(1'b0, 1'b0, 4'h3, rows[2], 1'b0, 1'b1);
    qchk(4'h3, 2'h1, rows[2]);
    for (int i = 0; i < 10 && exp_q.size() != 0; i++)
      @(posedge mclk_in);
    `CHK("pending", 0, exp_q.size())
    stop_test();
  end
endmodule : rpa_row_repair_tb_top
